// *** pkg/itfd_pkg.sv ***
// Package for the input terminal function decoder.
// Assumes one 100 MHz clock and terminals already level-shifted to logic levels.
package itfd_pkg;
   // Number of multi-function input terminals.
   localparam int unsigned NUM_TERM = 7;
   // Width of a per-terminal function code.
   localparam int unsigned FCODE_W = 7;
   // Clock period in nanoseconds.
   localparam int unsigned CLK_PERIOD_NS = 10;
   // Debounce time in microseconds.
   localparam int unsigned DEBOUNCE_US = 2;
   // Debounce time in clock cycles, rounded down, with no lower clamp.
   localparam int unsigned DEBOUNCE_CYC = (DEBOUNCE_US * 1000) / CLK_PERIOD_NS;
   // Width of the debounce counter.
   localparam int unsigned DB_CNT_W = $clog2(DEBOUNCE_CYC + 1);
   // External operation configuration values.
   localparam logic [2:0] OPCFG_FREE = 3'h0;
   localparam logic [2:0] OPCFG_FWD_REV = 3'h1;
   localparam logic [2:0] OPCFG_RUN_DIR = 3'h2;
   localparam logic [2:0] OPCFG_3WIRE = 3'h3;
   localparam logic [2:0] OPCFG_FWD_REV_Q = 3'h4;
   localparam logic [2:0] OPCFG_RUN_DIR_Q = 3'h5;
   localparam logic [2:0] OPCFG_3WIRE_Q = 3'h6;
   // Function codes handled here.
   localparam logic [6:0] FC_NONE = 7'h00;
   localparam logic [6:0] FC_STEP1 = 7'h01;
   localparam logic [6:0] FC_STEP2 = 7'h02;
   localparam logic [6:0] FC_STEP3 = 7'h03;
   localparam logic [6:0] FC_STEP4 = 7'h04;
   localparam logic [6:0] FC_RESET = 7'h05;
   localparam logic [6:0] FC_RAMP_HOLD = 7'h07;
   localparam logic [6:0] FC_ACC_SEL0 = 7'h08;
   localparam logic [6:0] FC_ACC_SEL1 = 7'h09;
   localparam logic [6:0] FC_EXT_FAULT = 7'h0A;
   localparam logic [6:0] FC_BASE_BLOCK = 7'h0B;
   localparam logic [6:0] FC_OUT_PAUSE = 7'h0C;
   // Terminal indices with fixed roles.
   localparam int unsigned T_ONE = 0;
   localparam int unsigned T_TWO = 1;
   localparam int unsigned T_THREE = 2;
   localparam int unsigned T_SEVEN = 6;

   // Decoded run command.
   typedef struct packed {
      logic run;
      logic reverse;
   } itfd_run_s;

   // Decoded auxiliary commands.
   typedef struct packed {
      logic [3:0] step_sel;
      logic [1:0] acc_sel;
      logic ramp_hold;
      logic fault_reset;
   } itfd_aux_s;

   // Output stage state, one-hot.
   typedef enum logic [3:0] {
      ITFD_ST_IDLE = 4'h1,
      ITFD_ST_RUN = 4'h2,
      ITFD_ST_BLOCK = 4'h4,
      ITFD_ST_PAUSE = 4'h8
   } itfd_state_e;
endpackage

// *** hdl/itfd_debounce.sv ***
// Debounce filter for one terminal.
// Passes the input through two flip-flops into the mclk domain first.
module itfd_debounce #(
   parameter int unsigned CYC = itfd_pkg::DEBOUNCE_CYC
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic sys_rst,
   // Raw and filtered level.
   input wire logic raw,
   output logic clean
);
   // All state of the filter.
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic level;
      logic [itfd_pkg::DB_CNT_W-1:0] cnt;
   } itfd_db_s;

   itfd_db_s st_r;
   itfd_db_s st_nxt;

   // The level changes only after the input differs for CYC cycles.
   always_comb begin
      st_nxt = st_r;
      st_nxt.sync1 = raw;
      st_nxt.sync2 = st_r.sync1;
      if (st_r.sync2 == st_r.level) begin
         st_nxt.cnt = '0;
      end else if (st_r.cnt == itfd_pkg::DB_CNT_W'(CYC - 1)) begin
         st_nxt.level = st_r.sync2;
         st_nxt.cnt = '0;
      end else begin
         st_nxt.cnt = st_r.cnt + 1'b1;
      end
   end

   // Registers the filter state.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign clean = st_r.level;
endmodule // itfd_debounce

// *** hdl/itfd_decoder.sv ***
// Multi-function input terminal decoder for a motor drive.
// Assumes normally open contacts reported as 1 when closed, and a ramp and
// output stage that consume the decoded commands.

// Contract
// - Config 1: terminal one forward, two reverse.
// - Config 2: terminal one run, two direction.
// - Terminal seven code 0 is pulse input.
// - Three-wire: terminal three is stop contact.
// - Closed contact means function on.
// - Codes 1-4 form four-bit step selector.
// - Code 5 resets fault once cause gone.
// - Code 7 freezes ramp while on.
// - Codes 8,9 select one of four ramps.
// - Code 10 records external fault, decelerates.
// - External fault held until clear and reset.
// - Code 11 base block cuts output.
// - Pause release restarts toward set frequency.
// - Config 0 frees terminals one and two.
module itfd_decoder #(
   parameter int unsigned NT = itfd_pkg::NUM_TERM
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic sys_rst,
   // Terminal contacts and configuration.
   input wire logic [NT-1:0] term_in,
   input wire logic [2:0] external_operation_config,
   input wire logic [NT*itfd_pkg::FCODE_W-1:0] term_fcode,
   input wire logic fault_stop_method,
   // Decoded commands.
   output itfd_pkg::itfd_run_s run_cmd,
   output itfd_pkg::itfd_aux_s aux_cmd,
   output logic output_enable,
   output logic coast,
   output logic decel_stop,
   output logic fault_stop_coast,
   output logic pulse_in,
   output logic external_fault,
   output logic base_block_ind,
   output logic pause_ind,
   output logic fault_active
);
   // Filtered terminal levels.
   logic [NT-1:0] term_clean;

   // All state of the decoder.
   typedef struct packed {
      itfd_pkg::itfd_state_e state;
      itfd_pkg::itfd_run_s run;
      itfd_pkg::itfd_aux_s aux;
      logic ef_latched;
      logic ef_prev;
      logic pulse;
      logic oe;
      logic coast;
   } itfd_core_s;

   itfd_core_s st_r;
   itfd_core_s st_nxt;

   // Per-terminal function activity, per code of interest.
   logic [NT-1:0] is_free;
   logic [NT-1:0] on_step1, on_step2, on_step3, on_step4;
   logic [NT-1:0] on_reset, on_hold, on_acc0, on_acc1, on_ef, on_bb, on_pause;

   // Each terminal is synchronised and debounced, then decoded.
   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : g_term
         logic [itfd_pkg::FCODE_W-1:0] fc;
         logic on;
         itfd_debounce #(
            .CYC(itfd_pkg::DEBOUNCE_CYC)
         ) u_db (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .raw(term_in[gi]),
            .clean(term_clean[gi])
         );
         assign fc = term_fcode[gi*itfd_pkg::FCODE_W +: itfd_pkg::FCODE_W];
         // Closed contact reads as the function being on.
         assign on = term_clean[gi] & is_free[gi];
         assign on_step1[gi] = on && (fc == itfd_pkg::FC_STEP1);
         assign on_step2[gi] = on && (fc == itfd_pkg::FC_STEP2);
         assign on_step3[gi] = on && (fc == itfd_pkg::FC_STEP3);
         assign on_step4[gi] = on && (fc == itfd_pkg::FC_STEP4);
         assign on_reset[gi] = on && (fc == itfd_pkg::FC_RESET);
         assign on_hold[gi] = on && (fc == itfd_pkg::FC_RAMP_HOLD);
         assign on_acc0[gi] = on && (fc == itfd_pkg::FC_ACC_SEL0);
         assign on_acc1[gi] = on && (fc == itfd_pkg::FC_ACC_SEL1);
         assign on_ef[gi] = on && (fc == itfd_pkg::FC_EXT_FAULT);
         assign on_bb[gi] = on && (fc == itfd_pkg::FC_BASE_BLOCK);
         assign on_pause[gi] = on && (fc == itfd_pkg::FC_OUT_PAUSE);
      end
   endgenerate

   // Configuration decode.
   logic cfg_free, cfg_fwd_rev, cfg_run_dir, cfg_3wire;
   logic [itfd_pkg::FCODE_W-1:0] fc_seven;

   always_comb begin
      cfg_free = (external_operation_config == itfd_pkg::OPCFG_FREE);
      cfg_fwd_rev = (external_operation_config == itfd_pkg::OPCFG_FWD_REV) ||
                    (external_operation_config == itfd_pkg::OPCFG_FWD_REV_Q);
      cfg_run_dir = (external_operation_config == itfd_pkg::OPCFG_RUN_DIR) ||
                    (external_operation_config == itfd_pkg::OPCFG_RUN_DIR_Q);
      cfg_3wire = (external_operation_config == itfd_pkg::OPCFG_3WIRE) ||
                  (external_operation_config == itfd_pkg::OPCFG_3WIRE_Q);
      fc_seven = term_fcode[itfd_pkg::T_SEVEN*itfd_pkg::FCODE_W +: itfd_pkg::FCODE_W];
      is_free = '1;
      // Terminals one and two take function codes only in config 0.
      is_free[itfd_pkg::T_ONE] = cfg_free;
      is_free[itfd_pkg::T_TWO] = cfg_free;
      // In three-wire mode terminal three's function code is ignored.
      is_free[itfd_pkg::T_THREE] = !cfg_3wire;
      // Code 0 on terminal seven makes it a pulse input.
      is_free[itfd_pkg::T_SEVEN] = (fc_seven != itfd_pkg::FC_NONE);
   end

   // Combined function levels.
   logic any_reset, any_ef, any_bb, any_pause, ef_rise;
   assign any_reset = |on_reset;
   assign any_ef = |on_ef;
   assign any_bb = |on_bb;
   assign any_pause = |on_pause;
   assign ef_rise = any_ef && !st_r.ef_prev;

   // Next-state logic for commands, fault latch and output stage.
   always_comb begin
      st_nxt = st_r;
      st_nxt.pulse = term_clean[itfd_pkg::T_SEVEN] && !is_free[itfd_pkg::T_SEVEN];
      // Run and direction from the configured wiring.
      if (cfg_fwd_rev) begin
         // Both closed stops and keeps the last direction.
         st_nxt.run.run = term_clean[itfd_pkg::T_ONE] ^ term_clean[itfd_pkg::T_TWO];
         if (term_clean[itfd_pkg::T_ONE] != term_clean[itfd_pkg::T_TWO]) begin
            st_nxt.run.reverse = term_clean[itfd_pkg::T_TWO];
         end
      end else if (cfg_run_dir) begin
         st_nxt.run.run = term_clean[itfd_pkg::T_ONE];
         st_nxt.run.reverse = term_clean[itfd_pkg::T_TWO];
      end else if (cfg_3wire) begin
         // Run latches on terminal one, open stop contact drops it.
         if (!term_clean[itfd_pkg::T_THREE]) begin
            st_nxt.run.run = 1'b0;
         end else if (term_clean[itfd_pkg::T_ONE]) begin
            st_nxt.run.run = 1'b1;
         end
         st_nxt.run.reverse = term_clean[itfd_pkg::T_TWO];
      end else begin
         st_nxt.run = '0;
      end
      // Step selector, ramp hold and ramp set selection.
      st_nxt.aux.step_sel = {|on_step4, |on_step3, |on_step2, |on_step1};
      st_nxt.aux.ramp_hold = |on_hold;
      st_nxt.aux.acc_sel = {|on_acc1, |on_acc0};
      st_nxt.aux.fault_reset = any_reset;
      // External fault: a new edge sets, reset clears only once the
      // terminal is open again; the set wins over the clear.
      st_nxt.ef_prev = any_ef;
      if (ef_rise) begin
         st_nxt.ef_latched = 1'b1;
      end else if (any_reset && !any_ef) begin
         st_nxt.ef_latched = 1'b0;
      end
      // Output stage: block and pause override run.
      unique case (st_r.state)
         itfd_pkg::ITFD_ST_IDLE: begin
            if (any_bb) st_nxt.state = itfd_pkg::ITFD_ST_BLOCK;
            else if (any_pause) st_nxt.state = itfd_pkg::ITFD_ST_PAUSE;
            else if (st_nxt.run.run) st_nxt.state = itfd_pkg::ITFD_ST_RUN;
         end
         itfd_pkg::ITFD_ST_RUN: begin
            if (any_bb) st_nxt.state = itfd_pkg::ITFD_ST_BLOCK;
            else if (any_pause) st_nxt.state = itfd_pkg::ITFD_ST_PAUSE;
            else if (!st_nxt.run.run) st_nxt.state = itfd_pkg::ITFD_ST_IDLE;
         end
         itfd_pkg::ITFD_ST_BLOCK: begin
            // A pause still held when the block lifts keeps the output waiting.
            if (!any_bb && any_pause) st_nxt.state = itfd_pkg::ITFD_ST_PAUSE;
            else if (!any_bb) st_nxt.state = itfd_pkg::ITFD_ST_IDLE;
         end
         itfd_pkg::ITFD_ST_PAUSE: begin
            if (any_bb) st_nxt.state = itfd_pkg::ITFD_ST_BLOCK;
            else if (!any_pause) begin
               // Release restarts toward the current set frequency.
               st_nxt.state = st_nxt.run.run ? itfd_pkg::ITFD_ST_RUN
                                             : itfd_pkg::ITFD_ST_IDLE;
            end
         end
         default: st_nxt.state = itfd_pkg::ITFD_ST_IDLE;
      endcase
      // Output cut by block or pause on the same edge that registers the new state, one cycle after the terminal decode.
      st_nxt.oe = (st_nxt.state == itfd_pkg::ITFD_ST_RUN);
      st_nxt.coast = (st_nxt.state == itfd_pkg::ITFD_ST_BLOCK) ||
                     (st_nxt.state == itfd_pkg::ITFD_ST_PAUSE);
   end

   // Registers the decoder state.
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_r <= '{state: itfd_pkg::ITFD_ST_IDLE, default: '0};
      end else begin
         st_r <= st_nxt;
      end
   end

   // Outputs, all from flip-flops except base_block_ind and pause_ind, decoded from the state, and fault_stop_coast, which is gated by fault_stop_method.
   assign run_cmd = st_r.run;
   assign aux_cmd = st_r.aux;
   assign output_enable = st_r.oe;
   assign coast = st_r.coast;
   assign decel_stop = st_r.ef_latched;
   assign fault_stop_coast = st_r.ef_latched & fault_stop_method;
   assign pulse_in = st_r.pulse;
   assign external_fault = st_r.ef_latched;
   assign base_block_ind = (st_r.state == itfd_pkg::ITFD_ST_BLOCK);
   assign pause_ind = (st_r.state == itfd_pkg::ITFD_ST_PAUSE);
   assign fault_active = st_r.ef_latched;

   // Named steps for fault behaviour.
   sequence s_ef_edge;
      ef_rise;
   endsequence

   a_ef_sets_fault: assert property (@(posedge mclk) disable iff (sys_rst)
      s_ef_edge |=> external_fault)
      else $error("External fault not recorded.");
   a_ef_held_closed: assert property (@(posedge mclk) disable iff (sys_rst)
      (external_fault && any_ef) |=> external_fault)
      else $error("External fault cleared while terminal closed.");
   a_ef_reset_clears: assert property (@(posedge mclk) disable iff (sys_rst)
      (external_fault && any_reset && !any_ef) |=> !external_fault)
      else $error("Reset did not clear external fault.");
   a_bb_cuts_output: assert property (@(posedge mclk) disable iff (sys_rst)
      any_bb |=> (!output_enable && coast && base_block_ind))
      else $error("Base block did not cut output.");
   a_pause_cuts_output: assert property (@(posedge mclk) disable iff (sys_rst)
      (any_pause && !any_bb) |=> (!output_enable && pause_ind))
      else $error("Pause did not cut output.");
   a_pause_release_run: assert property (@(posedge mclk) disable iff (sys_rst)
      (pause_ind && !any_pause && !any_bb && st_nxt.run.run) |=> output_enable)
      else $error("Output did not restart after pause.");
   a_override_run: assert property (@(posedge mclk) disable iff (sys_rst)
      output_enable |-> !(base_block_ind || pause_ind))
      else $error("Output enabled during block or pause.");
   a_step_select: assert property (@(posedge mclk) disable iff (sys_rst)
      1'b1 |=> aux_cmd.step_sel == $past({|on_step4, |on_step3, |on_step2, |on_step1}))
      else $error("Step selector mismatch.");
   a_run_dir_mode: assert property (@(posedge mclk) disable iff (sys_rst)
      cfg_run_dir |=> (run_cmd.run == $past(term_clean[itfd_pkg::T_ONE])))
      else $error("Run not following terminal one.");
endmodule // itfd_decoder

// *** tb/itfd_contacts.sv ***
// Behavioural model of the external contacts wired to the seven terminals.
// Assumes the bench moves the wanted contact state just after a rising edge of mclk.
module itfd_contacts (
   // Clock.
   input wire logic mclk,
   // Wanted contact state, 1 = closed, and a switch that makes moves chatter.
   input wire logic [6:0] want,
   input wire logic bounce_en,
   // Levels seen at the terminals.
   output logic [6:0] term_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // Last wanted state, so that a move can be seen.
   logic [6:0] prev_r = 7'h00;
   // Contacts that moved last, which are the ones that chatter.
   logic [6:0] moved_r = 7'h00;
   // Cycles of chatter left after a move.
   logic [4:0] chat_r = 5'h00;

   // A closed contact pulls the terminal to 1, an open one leaves it at 0.
   // While chatter lasts, the moved contacts flip back every other cycle.
   always @(posedge mclk) begin
      prev_r <= want;
      if (want != prev_r && bounce_en) begin
         moved_r <= want ^ prev_r;
         chat_r <= 5'h14;
      end else if (chat_r != 5'h00) begin
         chat_r <= chat_r - 5'h01;
      end
      term_in <= (chat_r[0]) ? (want ^ moved_r) : want;
   end
endmodule // itfd_contacts

// *** tb/tb.sv ***
// Self-checking bench for the input terminal function decoder.
// Assumes the contact model drives the terminals and each level change settles in 240 cycles.
module tb;
   timeunit 1ns;
   timeprecision 1ps;

   // Clock, reset and stimulus.
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [6:0] want = 7'h00;
   logic bounce_en = 1'b0;
   logic [6:0] term_in;
   logic [2:0] cfg = 3'h0;
   logic [48:0] fcode = 49'h0;
   logic fsm = 1'b0;
   // Decoded outputs.
   itfd_pkg::itfd_run_s run_cmd;
   itfd_pkg::itfd_aux_s aux_cmd;
   logic output_enable, coast, decel_stop, fault_stop_coast, pulse_in;
   logic external_fault, base_block_ind, pause_ind, fault_active;
   // Output stage and run state packed for compact compares.
   wire logic [7:0] st = {output_enable, coast, base_block_ind, pause_ind,
                          external_fault, fault_active, run_cmd.run, run_cmd.reverse};
   // Fault outputs packed for compact compares.
   wire logic [3:0] flt = {decel_stop, fault_stop_coast, external_fault, fault_active};
   // Counters for the closing report.
   int bad_count = 0;
   int n_compared = 0;

   // Free-running 100 MHz clock.
   always #5 mclk = ~mclk;

   itfd_contacts i_itfd_contacts (.mclk(mclk), .want(want), .bounce_en(bounce_en),
                                  .term_in(term_in));

   itfd_decoder i_itfd_decoder (.mclk(mclk), .sys_rst(sys_rst), .term_in(term_in),
      .external_operation_config(cfg), .term_fcode(fcode), .fault_stop_method(fsm),
      .run_cmd(run_cmd), .aux_cmd(aux_cmd), .output_enable(output_enable), .coast(coast),
      .decel_stop(decel_stop), .fault_stop_coast(fault_stop_coast), .pulse_in(pulse_in),
      .external_fault(external_fault), .base_block_ind(base_block_ind),
      .pause_ind(pause_ind), .fault_active(fault_active));

   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Assigns a function code to terminal t, counted from zero.
   task automatic set_code(input int t, input logic [6:0] c);
      @(posedge mclk);
      fcode[7*t +: 7] <= c;
   endtask

   // Moves the contacts, then waits out chatter, sync, debounce and decode.
   task automatic apply(input logic [6:0] w, input int n = 240);
      @(posedge mclk);
      want <= w;
      repeat (n) @(posedge mclk);
      #1;
   endtask

   // Watchdog so that a hang still reaches the report.
   initial begin
      repeat (60000) @(posedge mclk);
      bad_count++;
      summarize();
   end

   // Main sequence.
   initial begin
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
      chk(st, 8'h00);
      chk(aux_cmd, 8'h00);
      // Two-wire forward/reverse; codes on terminals one and two must be ignored.
      set_code(0, itfd_pkg::FC_BASE_BLOCK);
      set_code(1, itfd_pkg::FC_OUT_PAUSE);
      @(posedge mclk) cfg <= itfd_pkg::OPCFG_FWD_REV;
      apply(7'h01);
      chk(st, 8'h82);
      apply(7'h02);
      chk(st, 8'h83);
      apply(7'h03);
      chk(st, 8'h01);
      apply(7'h00);
      // Two-wire run/direction, with chattering contacts.
      @(posedge mclk) cfg <= itfd_pkg::OPCFG_RUN_DIR;
      bounce_en <= 1'b1;
      apply(7'h01);
      chk(st, 8'h82);
      apply(7'h03);
      chk(st, 8'h83);
      apply(7'h02);
      chk(st, 8'h01);
      bounce_en <= 1'b0;
      // Free terminals: step selector from codes one to four.
      @(posedge mclk) cfg <= itfd_pkg::OPCFG_FREE;
      for (int k = 0; k < 4; k++) begin
         set_code(k, itfd_pkg::FC_STEP1 + 7'(k));
      end
      for (int k = 0; k < 4; k++) begin
         apply(7'h01 << k);
         chk({4'h0, aux_cmd.step_sel}, 8'h01 << k);
      end
      apply(7'h0F);
      chk({4'h0, aux_cmd.step_sel}, 8'h0F);
      chk(st, 8'h00);
      // Ramp set selector from codes eight and nine.
      set_code(4, itfd_pkg::FC_ACC_SEL0);
      set_code(5, itfd_pkg::FC_ACC_SEL1);
      for (int k = 1; k < 4; k++) begin
         apply(7'(k << 4));
         chk({6'h00, aux_cmd.acc_sel}, 8'(k));
      end
      // Ramp hold and pulse input.
      set_code(4, itfd_pkg::FC_RAMP_HOLD);
      apply(7'h10);
      chk({7'h00, aux_cmd.ramp_hold}, 8'h01);
      apply(7'h40);
      chk({7'h00, aux_cmd.ramp_hold}, 8'h00);
      chk({7'h00, pulse_in}, 8'h01);
      apply(7'h00);
      chk({7'h00, pulse_in}, 8'h00);
      // External fault, held until the contact opens and a reset arrives.
      @(posedge mclk) cfg <= itfd_pkg::OPCFG_RUN_DIR;
      fsm <= 1'b1;
      set_code(2, itfd_pkg::FC_NONE);
      set_code(3, itfd_pkg::FC_EXT_FAULT);
      set_code(4, itfd_pkg::FC_RESET);
      set_code(5, itfd_pkg::FC_BASE_BLOCK);
      set_code(6, itfd_pkg::FC_OUT_PAUSE);
      apply(7'h01);
      chk(st, 8'h82);
      apply(7'h09);
      chk({4'h0, flt}, 8'h0F);
      apply(7'h19);
      chk({4'h0, flt}, 8'h0F);
      chk({7'h00, aux_cmd.fault_reset}, 8'h01);
      // A decelerating stop method leaves the coast request low.
      fsm <= 1'b0;
      apply(7'h01);
      chk({4'h0, flt}, 8'h0B);
      apply(7'h11);
      chk({4'h0, flt}, 8'h00);
      // Base block and pause override the run command.
      apply(7'h21);
      chk(st & 8'hF0, 8'h60);
      apply(7'h41);
      chk(st & 8'hF0, 8'h50);
      apply(7'h61);
      chk(st & 8'hF0, 8'h60);
      apply(7'h01);
      chk(st & 8'hF0, 8'h80);
      // Pause alone, then its release returns straight to running.
      apply(7'h41);
      chk(st & 8'hF0, 8'h50);
      apply(7'h01);
      chk(st & 8'hF0, 8'h80);
      apply(7'h00);
      // Three-wire: terminal three is the stop contact whatever its code.
      set_code(2, itfd_pkg::FC_BASE_BLOCK);
      @(posedge mclk) cfg <= itfd_pkg::OPCFG_3WIRE;
      apply(7'h04);
      chk(st, 8'h00);
      apply(7'h05);
      chk(st, 8'h82);
      apply(7'h04);
      chk(st, 8'h82);
      apply(7'h06);
      chk(st, 8'h83);
      apply(7'h00);
      chk(st, 8'h00);
      // A closure shorter than the filter time must not reach the outputs.
      @(posedge mclk) cfg <= itfd_pkg::OPCFG_RUN_DIR;
      apply(7'h01, 50);
      apply(7'h00);
      chk(st, 8'h00);
      summarize();
   end
endmodule // tb
